/* File: verilog/via_arbiter.sv */
// Vectored interrupt arbiter: flags, masks, priority groups, vectoring
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
module via_arbiter
  import via_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [7:0] rd_data_out,
  input wire logic [5:0] ext_pin_in,
  input wire logic lowvolt_detect_in,
  input wire logic uart6_rx_err_in,
  input wire logic uart6_rx_end_in,
  input wire logic uart6_tx_end_in,
  input wire logic csi_transfer_end_irq_in,
  input wire logic uart0_tx_end_irq_in,
  input wire logic timerh1_match_in,
  input wire logic timerh0_match_in,
  input wire logic timer50_match_irq_in,
  input wire logic timer00_ch0_match_in,
  input wire logic timer00_ch0_capture_mode_in,
  input wire logic timer16_input_b_edge_in,
  input wire logic timer00_ch1_match_in,
  input wire logic timer00_ch1_capture_mode_in,
  input wire logic timer16_input_a_edge_in,
  input wire logic adc_done_irq_in,
  input wire logic uart0_rx_end_in,
  input wire logic uart0_rx_err_in,
  input wire logic timer51_match_irq_in,
  input wire logic timer51_carrier_mode_in,
  input wire logic carrier_timer_event_in,
  input wire logic twowire_done_irq_in,
  input wire logic ack_in,
  input wire logic service_return_in,
  output logic irq_req_out,
  output logic [15:0] vector_out,
  output logic irq_high_group_out,
  output logic lowvolt_reset_out
);

  // ==========================================================
  // Byte views of the 20-wide flag vectors
  function automatic logic [7:0] via_get_byte(input logic [19:0] v, input logic [1:0] grp, input logic fill);
    logic [7:0] b;
    b = {8{fill}};
    case (grp)
      2'd0: b = v[7:0];
      2'd1: b = v[15:8];
      2'd2: b = {{4{fill}}, v[18], fill, v[17], v[16]};
      default: b = {{7{fill}}, v[19]};
    endcase
    return b;
  endfunction : via_get_byte

  function automatic logic [19:0] via_put_byte(input logic [19:0] v, input logic [1:0] grp, input logic [7:0] d);
    logic [19:0] r;
    r = v;
    case (grp)
      2'd0: r[7:0] = d;
      2'd1: r[15:8] = d;
      2'd2: begin
        r[16] = d[0];
        r[17] = d[1];
        r[18] = d[3];
      end
      default: r[19] = d[0];
    endcase
    return r;
  endfunction : via_put_byte

  // ==========================================================
  // External pin edge detection
  logic [5:0] rise_en_reg;
  logic [5:0] rise_en_next;
  logic [5:0] fall_en_reg;
  logic [5:0] fall_en_next;
  logic [5:0] pin_pulse;

  via_pin_edge #(
    .WIDTH(VIA_NUM_PINS)
  ) i_via_pin_edge (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .pin_in(ext_pin_in),
    .rising_edge_enables_in(rise_en_reg),
    .falling_edge_enables_in(fall_en_reg),
    .edge_pulse_out(pin_pulse)
  );

  // ==========================================================
  // Source events, index equals default priority
  logic lowvolt_mode_select_reg;
  logic lowvolt_mode_select_next;
  logic [19:0] src_event;

  always_comb begin
    src_event[0] = lowvolt_detect_in & ~lowvolt_mode_select_reg;
    src_event[6:1] = pin_pulse;
    src_event[7] = uart6_rx_err_in;
    src_event[8] = uart6_rx_end_in;
    src_event[9] = uart6_tx_end_in;
    src_event[VIA_IDX_SHARED] = csi_transfer_end_irq_in | uart0_tx_end_irq_in;
    src_event[11] = timerh1_match_in;
    src_event[12] = timerh0_match_in;
    src_event[13] = timer50_match_irq_in;
    src_event[14] = timer00_ch0_capture_mode_in ? timer16_input_b_edge_in : timer00_ch0_match_in;
    src_event[15] = timer00_ch1_capture_mode_in ? timer16_input_a_edge_in : timer00_ch1_match_in;
    src_event[16] = adc_done_irq_in;
    src_event[17] = uart0_rx_end_in | uart0_rx_err_in;
    src_event[VIA_IDX_TIMER8_B_COUNTER] = timer51_carrier_mode_in ? carrier_timer_event_in : timer51_match_irq_in;
    src_event[VIA_IDX_TWOWIRE] = twowire_done_irq_in;
  end

  // ==========================================================
  // Arbitration over eligible requests
  logic [19:0] req_reg;
  logic [19:0] mask_reg;
  logic [19:0] prio_reg;
  logic ie_reg;
  logic hi_busy_reg;
  logic lo_busy_reg;
  logic [19:0] eligible;
  logic found;
  logic [4:0] win_idx;
  logic win_high;

  always_comb begin
    eligible = '0;
    found = 1'b0;
    win_idx = 5'h00;
    win_high = 1'b0;
    for (int i = 0; i < VIA_NUM_SRC; i++) begin
      // High group blocked only by high service; low by any service
      if (req_reg[i] && !mask_reg[i] && ie_reg && !hi_busy_reg && (!prio_reg[i] || !lo_busy_reg)) begin
        eligible[i] = 1'b1;
      end
    end
    for (int i = VIA_NUM_SRC - 1; i >= 0; i--) begin
      if (eligible[i] && !prio_reg[i]) begin
        found = 1'b1;
        win_idx = 5'(i);
        win_high = 1'b1;
      end
    end
    if (!found) begin
      for (int i = VIA_NUM_SRC - 1; i >= 0; i--) begin
        if (eligible[i]) begin
          found = 1'b1;
          win_idx = 5'(i);
        end
      end
    end
  end

  // ==========================================================
  // Request presentation toward the core
  logic irq_req_reg;
  logic irq_req_next;
  logic [15:0] vector_reg;
  logic [15:0] vector_next;
  logic irq_high_reg;
  logic irq_high_next;
  logic [4:0] pend_idx_reg;
  logic [4:0] pend_idx_next;
  logic ack_take;

  assign ack_take = ack_in & irq_req_reg;

  always_comb begin
    irq_req_next = found & ~ack_take;
    irq_high_next = win_high;
    pend_idx_next = win_idx;
    if (win_idx == 5'(VIA_IDX_TIMER8_B_COUNTER)) begin
      vector_next = VIA_VEC_TIMER8_B_COUNTER;
    end else if (win_idx == 5'(VIA_IDX_TWOWIRE)) begin
      vector_next = VIA_VEC_TWOWIRE;
    end else begin
      vector_next = VIA_VEC_BASE + {10'h000, win_idx, 1'b0};
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_req_reg <= 1'b0;
      vector_reg <= 16'h0000;
      irq_high_reg <= 1'b0;
      pend_idx_reg <= 5'h00;
    end else begin
      irq_req_reg <= irq_req_next;
      vector_reg <= vector_next;
      irq_high_reg <= irq_high_next;
      pend_idx_reg <= pend_idx_next;
    end
  end

  // ==========================================================
  // Flag registers, enables, service state
  logic [19:0] req_next;
  logic [19:0] mask_next;
  logic [19:0] prio_next;
  logic ie_next;
  logic hi_busy_next;
  logic lo_busy_next;
  logic lowvolt_reset_reg;
  logic lowvolt_reset_next;

  always_comb begin
    req_next = req_reg;
    mask_next = mask_reg;
    prio_next = prio_reg;
    rise_en_next = rise_en_reg;
    fall_en_next = fall_en_reg;
    lowvolt_mode_select_next = lowvolt_mode_select_reg;
    ie_next = ie_reg;
    hi_busy_next = hi_busy_reg;
    lo_busy_next = lo_busy_reg;
    if (wr_en_in) begin
      if (addr_in == VIA_ADDR_REQ0L) begin
        req_next = via_put_byte(req_reg, 2'd0, wr_data_in);
      end else if (addr_in == VIA_ADDR_REQ0H) begin
        req_next = via_put_byte(req_reg, 2'd1, wr_data_in);
      end else if (addr_in == VIA_ADDR_REQ1L) begin
        req_next = via_put_byte(req_reg, 2'd2, wr_data_in);
      end else if (addr_in == VIA_ADDR_REQ1H) begin
        req_next = via_put_byte(req_reg, 2'd3, wr_data_in);
      end else if (addr_in == VIA_ADDR_MASK0L) begin
        mask_next = via_put_byte(mask_reg, 2'd0, wr_data_in);
      end else if (addr_in == VIA_ADDR_MASK0H) begin
        mask_next = via_put_byte(mask_reg, 2'd1, wr_data_in);
      end else if (addr_in == VIA_ADDR_MASK1L) begin
        mask_next = via_put_byte(mask_reg, 2'd2, wr_data_in);
      end else if (addr_in == VIA_ADDR_MASK1H) begin
        mask_next = via_put_byte(mask_reg, 2'd3, wr_data_in);
      end else if (addr_in == VIA_ADDR_PRIO0L) begin
        prio_next = via_put_byte(prio_reg, 2'd0, wr_data_in);
      end else if (addr_in == VIA_ADDR_PRIO0H) begin
        prio_next = via_put_byte(prio_reg, 2'd1, wr_data_in);
      end else if (addr_in == VIA_ADDR_PRIO1L) begin
        prio_next = via_put_byte(prio_reg, 2'd2, wr_data_in);
      end else if (addr_in == VIA_ADDR_PRIO1H) begin
        prio_next = via_put_byte(prio_reg, 2'd3, wr_data_in);
      end else if (addr_in == VIA_ADDR_RISE_EN) begin
        rise_en_next = wr_data_in[5:0];
      end else if (addr_in == VIA_ADDR_FALL_EN) begin
        fall_en_next = wr_data_in[5:0];
      end else if (addr_in == VIA_ADDR_LOWVOLT) begin
        lowvolt_mode_select_next = wr_data_in[VIA_LOWVOLT_MODE_BIT];
      end else if (addr_in == VIA_ADDR_CTRL) begin
        ie_next = wr_data_in[VIA_CTRL_IE_BIT];
      end
    end
    // Acknowledge: clear flag, block nesting by the same or a lower group, disable further accepts
    if (ack_take) begin
      req_next[pend_idx_reg] = 1'b0;
      ie_next = 1'b0;
      if (irq_high_reg) begin
        hi_busy_next = 1'b1;
      end else begin
        lo_busy_next = 1'b1;
      end
    end else if (service_return_in) begin
      if (hi_busy_reg) begin
        hi_busy_next = 1'b0;
      end else begin
        lo_busy_next = 1'b0;
      end
    end
    // Hardware set wins over software or acknowledge clear
    req_next = req_next | src_event;
    lowvolt_reset_next = lowvolt_detect_in & lowvolt_mode_select_reg;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      req_reg <= VIA_REQ_RESET;
      mask_reg <= VIA_MASK_RESET;
      prio_reg <= VIA_PRIO_RESET;
      rise_en_reg <= 6'h00;
      fall_en_reg <= 6'h00;
      lowvolt_mode_select_reg <= 1'b0;
      ie_reg <= 1'b0;
      hi_busy_reg <= 1'b0;
      lo_busy_reg <= 1'b0;
      lowvolt_reset_reg <= 1'b0;
    end else begin
      req_reg <= req_next;
      mask_reg <= mask_next;
      prio_reg <= prio_next;
      rise_en_reg <= rise_en_next;
      fall_en_reg <= fall_en_next;
      lowvolt_mode_select_reg <= lowvolt_mode_select_next;
      ie_reg <= ie_next;
      hi_busy_reg <= hi_busy_next;
      lo_busy_reg <= lo_busy_next;
      lowvolt_reset_reg <= lowvolt_reset_next;
    end
  end

  // ==========================================================
  // Read path, data one cycle after the strobe
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;

  always_comb begin
    rd_data_next = VIA_BYTE_RESET;
    if (rd_en_in) begin
      if (addr_in == VIA_ADDR_REQ0L) begin
        rd_data_next = via_get_byte(req_reg, 2'd0, 1'b0);
      end else if (addr_in == VIA_ADDR_REQ0H) begin
        rd_data_next = via_get_byte(req_reg, 2'd1, 1'b0);
      end else if (addr_in == VIA_ADDR_REQ1L) begin
        rd_data_next = via_get_byte(req_reg, 2'd2, 1'b0);
      end else if (addr_in == VIA_ADDR_REQ1H) begin
        rd_data_next = via_get_byte(req_reg, 2'd3, 1'b0);
      end else if (addr_in == VIA_ADDR_MASK0L) begin
        rd_data_next = via_get_byte(mask_reg, 2'd0, 1'b1);
      end else if (addr_in == VIA_ADDR_MASK0H) begin
        rd_data_next = via_get_byte(mask_reg, 2'd1, 1'b1);
      end else if (addr_in == VIA_ADDR_MASK1L) begin
        rd_data_next = via_get_byte(mask_reg, 2'd2, 1'b1);
      end else if (addr_in == VIA_ADDR_MASK1H) begin
        rd_data_next = via_get_byte(mask_reg, 2'd3, 1'b1);
      end else if (addr_in == VIA_ADDR_PRIO0L) begin
        rd_data_next = via_get_byte(prio_reg, 2'd0, 1'b1);
      end else if (addr_in == VIA_ADDR_PRIO0H) begin
        rd_data_next = via_get_byte(prio_reg, 2'd1, 1'b1);
      end else if (addr_in == VIA_ADDR_PRIO1L) begin
        rd_data_next = via_get_byte(prio_reg, 2'd2, 1'b1);
      end else if (addr_in == VIA_ADDR_PRIO1H) begin
        rd_data_next = via_get_byte(prio_reg, 2'd3, 1'b1);
      end else if (addr_in == VIA_ADDR_RISE_EN) begin
        rd_data_next = {2'b00, rise_en_reg};
      end else if (addr_in == VIA_ADDR_FALL_EN) begin
        rd_data_next = {2'b00, fall_en_reg};
      end else if (addr_in == VIA_ADDR_LOWVOLT) begin
        rd_data_next = {6'h00, lowvolt_mode_select_reg, 1'b0};
      end else if (addr_in == VIA_ADDR_CTRL) begin
        rd_data_next = {7'h00, ie_reg};
      end else if (addr_in == VIA_ADDR_STATUS) begin
        rd_data_next = {irq_req_reg, 2'b00, lo_busy_reg, hi_busy_reg, irq_high_reg, 2'b00};
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_data_reg <= VIA_BYTE_RESET;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  // Outputs straight from flip-flops
  assign rd_data_out = rd_data_reg;
  assign irq_req_out = irq_req_reg;
  assign vector_out = vector_reg;
  assign irq_high_group_out = irq_high_reg;
  assign lowvolt_reset_out = lowvolt_reset_reg;

endmodule : via_arbiter

/* File: verilog/via_pkg.sv */
// Constants shared by the vectored interrupt arbiter
package via_pkg;

  // ==========================================================
  // Source count and register map
  localparam int unsigned VIA_NUM_SRC = 20;
  localparam int unsigned VIA_NUM_PINS = 6;
  localparam logic [7:0] VIA_ADDR_REQ0L = 8'he0;
  localparam logic [7:0] VIA_ADDR_REQ0H = 8'he1;
  localparam logic [7:0] VIA_ADDR_REQ1L = 8'he2;
  localparam logic [7:0] VIA_ADDR_REQ1H = 8'he3;
  localparam logic [7:0] VIA_ADDR_MASK0L = 8'he4;
  localparam logic [7:0] VIA_ADDR_MASK0H = 8'he5;
  localparam logic [7:0] VIA_ADDR_MASK1L = 8'he6;
  localparam logic [7:0] VIA_ADDR_MASK1H = 8'he7;
  localparam logic [7:0] VIA_ADDR_PRIO0L = 8'he8;
  localparam logic [7:0] VIA_ADDR_PRIO0H = 8'he9;
  localparam logic [7:0] VIA_ADDR_PRIO1L = 8'hea;
  localparam logic [7:0] VIA_ADDR_PRIO1H = 8'heb;
  localparam logic [7:0] VIA_ADDR_RISE_EN = 8'h48;
  localparam logic [7:0] VIA_ADDR_FALL_EN = 8'h49;
  localparam logic [7:0] VIA_ADDR_LOWVOLT = 8'hbe;
  localparam logic [7:0] VIA_ADDR_CTRL = 8'hf0;
  localparam logic [7:0] VIA_ADDR_STATUS = 8'hf1;

  // ==========================================================
  // Field positions
  localparam int unsigned VIA_LOWVOLT_MODE_BIT = 1;
  localparam int unsigned VIA_CTRL_IE_BIT = 0;
  localparam int unsigned VIA_IDX_SHARED = 10;
  localparam int unsigned VIA_IDX_TIMER8_B_COUNTER = 18;
  localparam int unsigned VIA_IDX_TWOWIRE = 19;

  // ==========================================================
  // Reset values
  localparam logic [19:0] VIA_REQ_RESET = 20'h00000;
  localparam logic [19:0] VIA_MASK_RESET = 20'hfffff;
  localparam logic [19:0] VIA_PRIO_RESET = 20'hfffff;
  localparam logic [7:0] VIA_BYTE_RESET = 8'h00;

  // ==========================================================
  // Vector table addresses
  localparam logic [15:0] VIA_VEC_BASE = 16'h0004;
  localparam logic [15:0] VIA_VEC_TIMER8_B_COUNTER = 16'h002a;
  localparam logic [15:0] VIA_VEC_TWOWIRE = 16'h0034;

  // Pin synchroniser depth
  localparam int unsigned VIA_SYNC_STAGES = 3;

endpackage : via_pkg

/* File: verilog/via_pin_edge.sv */
// Pin synchroniser and edge selector for the external request pins
`timescale 1ns/1ps
module via_pin_edge
  import via_pkg::*;
#(
  parameter int unsigned WIDTH = VIA_NUM_PINS
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] rising_edge_enables_in,
  input wire logic [WIDTH-1:0] falling_edge_enables_in,
  output logic [WIDTH-1:0] edge_pulse_out
);

  // ==========================================================
  // Per-pin synchroniser, agreement and edge detection
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      logic [2:0] sync_reg;
      logic [2:0] sync_next;
      logic level_reg;
      logic level_next;
      logic pulse_reg;
      logic pulse_next;

      // Next values: level changes once stages two and three agree
      always_comb begin
        sync_next = {sync_reg[1:0], pin_in[g]};
        level_next = level_reg;
        pulse_next = 1'b0;
        if (sync_reg[1] == sync_reg[2]) begin
          level_next = sync_reg[2];
          if (sync_reg[2] && !level_reg && rising_edge_enables_in[g]) begin
            pulse_next = 1'b1;
          end else if (!sync_reg[2] && level_reg && falling_edge_enables_in[g]) begin
            pulse_next = 1'b1;
          end
        end
      end

      // Registers
      always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          sync_reg <= 3'h0;
          level_reg <= 1'b0;
          pulse_reg <= 1'b0;
        end else begin
          sync_reg <= sync_next;
          level_reg <= level_next;
          pulse_reg <= pulse_next;
        end
      end

      assign edge_pulse_out[g] = pulse_reg;
    end
  endgenerate

endmodule : via_pin_edge

/* File: tb/via_arbiter_properties.sv */
// Checker for the vectored interrupt arbiter ports
`timescale 1ns/1ps
module via_arbiter_checker
  import via_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] rd_data_out,
  input wire logic lowvolt_detect_in,
  input wire logic ack_in,
  input wire logic service_return_in,
  input wire logic irq_req_out,
  input wire logic [15:0] vector_out,
  input wire logic irq_high_group_out,
  input wire logic lowvolt_reset_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  logic mode_q, ie_q, hi_q, lo_q;
  wire taken = ack_in && irq_req_out;
  // ==========================================================
  // Shadow of mode, enable and in-service state
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_q <= 1'b0;
      ie_q <= 1'b0;
      hi_q <= 1'b0;
      lo_q <= 1'b0;
    end else begin
      if (wr_en_in && addr_in == VIA_ADDR_LOWVOLT) mode_q <= wr_data_in[VIA_LOWVOLT_MODE_BIT];
      if (taken) ie_q <= 1'b0;
      else if (wr_en_in && addr_in == VIA_ADDR_CTRL) ie_q <= wr_data_in[VIA_CTRL_IE_BIT];
      if (taken) begin
        if (irq_high_group_out) hi_q <= 1'b1;
        else lo_q <= 1'b1;
      end else if (service_return_in) begin
        if (hi_q) hi_q <= 1'b0;
        else lo_q <= 1'b0;
      end
    end
  end
  // ==========================================================
  // Properties
  a_ack_drops_req: assert property (taken |=> !irq_req_out)
    else $error("request still up after acknowledge");
  a_ie_gate_req: assert property (!ie_q |=> !irq_req_out)
    else $error("request with global enable off");
  a_hi_blocks_all: assert property (hi_q |=> !irq_req_out)
    else $error("request while high group in service");
  a_lo_high_only: assert property (lo_q |=> (!irq_req_out || irq_high_group_out))
    else $error("low request nested over low service");
  a_vec_legal: assert property (irq_req_out |-> ((vector_out[0] == 1'b0 && vector_out >= 16'h0004 &&
    vector_out <= 16'h0026) || vector_out == VIA_VEC_TIMER8_B_COUNTER || vector_out == VIA_VEC_TWOWIRE))
    else $error("vector outside table");
  a_lv_reset_on: assert property (lowvolt_detect_in && mode_q |=> lowvolt_reset_out)
    else $error("no reset from low voltage");
  a_lv_irq_mode: assert property (lowvolt_detect_in && !mode_q |=> !lowvolt_reset_out)
    else $error("reset from low voltage in interrupt mode");
  a_rd_idle_zero: assert property (!rd_en_in |=> rd_data_out == 8'h00)
    else $error("read data outside read cycle");
  a_rd_unmapped: assert property (rd_en_in && addr_in < 8'h48 |=> rd_data_out == 8'h00)
    else $error("unmapped read not zero");
  c_high_taken: cover property (taken && irq_high_group_out);
  c_lv_reset: cover property (lowvolt_reset_out);
  c_nested: cover property (lo_q && irq_req_out);
endmodule : via_arbiter_checker

bind via_arbiter via_arbiter_checker i_via_arbiter_checker(.clk_in(clk_in), .reset_n_in(reset_n_in),
  .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
  .rd_data_out(rd_data_out), .lowvolt_detect_in(lowvolt_detect_in), .ack_in(ack_in),
  .service_return_in(service_return_in), .irq_req_out(irq_req_out), .vector_out(vector_out),
  .irq_high_group_out(irq_high_group_out), .lowvolt_reset_out(lowvolt_reset_out));

/* File: tb/via_core_model.sv */
// Processor core model that acknowledges requests
`timescale 1ns/1ps
module via_core_model (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic enable_in,
  input wire logic slow_in,
  input wire logic irq_req_in,
  input wire logic [15:0] vector_in,
  output logic ack_out,
  output logic [15:0] taken_vec_out,
  output logic [7:0] taken_count_out
);
  logic [1:0] wait_reg;
  // ==========================================================
  // Acknowledge after zero or three idle cycles, latch vector
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_out <= 1'b0;
      wait_reg <= 2'h0;
      taken_vec_out <= 16'h0000;
      taken_count_out <= 8'h00;
    end else begin
      wait_reg <= (irq_req_in && !ack_out) ? wait_reg + 2'h1 : 2'h0;
      ack_out <= enable_in && irq_req_in && !ack_out && (!slow_in || wait_reg == 2'h3);
      if (ack_out && irq_req_in) begin
        taken_vec_out <= vector_in;
        taken_count_out <= taken_count_out + 8'h01;
      end
    end
  end
endmodule : via_core_model

/* File: tb/via_arbiter_test.sv */
// Self-checking testbench for the vectored interrupt arbiter
`timescale 1ns/1ps
module via_arbiter_test;
  import via_pkg::*;
  logic clk_in = 0, reset_n_in = 0, wr = 0, rd = 0, ret = 0, cap0 = 0, cap1 = 0, carm = 0, slow = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, tcnt;
  logic [5:0] pins = 6'h02;
  logic [18:0] ev = 19'h0;
  logic ack, irq, high, lvr;
  logic [15:0] vec, tvec;
  int errors = 0, check_count = 0;
  int evb[11] = '{0, 4, 5, 8, 9, 11, 13, 14, 15, 16, 18};
  logic [15:0] evv[11] = '{16'h0004, 16'h0018, 16'h0018, 16'h001e, 16'h0020, 16'h0022, 16'h0024,
    16'h0026, 16'h0026, 16'h002a, 16'h0034};
  // ==========================================================
  // Clock and instances
  always #12.5 clk_in = ~clk_in;
  via_arbiter i_via_arbiter(.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr), .wr_data_in(wdata),
    .wr_en_in(wr), .rd_en_in(rd), .rd_data_out(rdata), .ext_pin_in(pins), .lowvolt_detect_in(ev[0]),
    .uart6_rx_err_in(ev[1]), .uart6_rx_end_in(ev[2]), .uart6_tx_end_in(ev[3]),
    .csi_transfer_end_irq_in(ev[4]), .uart0_tx_end_irq_in(ev[5]), .timerh1_match_in(ev[6]),
    .timerh0_match_in(ev[7]), .timer50_match_irq_in(ev[8]), .timer00_ch0_match_in(ev[9]),
    .timer00_ch0_capture_mode_in(cap0), .timer16_input_b_edge_in(ev[10]), .timer00_ch1_match_in(ev[11]),
    .timer00_ch1_capture_mode_in(cap1), .timer16_input_a_edge_in(ev[12]), .adc_done_irq_in(ev[13]),
    .uart0_rx_end_in(ev[14]), .uart0_rx_err_in(ev[15]), .timer51_match_irq_in(ev[16]),
    .timer51_carrier_mode_in(carm), .carrier_timer_event_in(ev[17]), .twowire_done_irq_in(ev[18]),
    .ack_in(ack), .service_return_in(ret), .irq_req_out(irq), .vector_out(vec),
    .irq_high_group_out(high), .lowvolt_reset_out(lvr));
  via_core_model i_via_core_model(.clk_in(clk_in), .reset_n_in(reset_n_in), .enable_in(1'b1),
    .slow_in(slow), .irq_req_in(irq), .vector_in(vec), .ack_out(ack), .taken_vec_out(tvec),
    .taken_count_out(tcnt));
  // ==========================================================
  // Bus, event and compare tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic wrb(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wrb
  task automatic rdb(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, exp}, "read data");
  endtask : rdb
  task automatic pulse(input logic [18:0] v);
    @(posedge clk_in);
    ev <= v;
    @(posedge clk_in);
    ev <= 19'h0;
  endtask : pulse
  task automatic back();
    @(posedge clk_in);
    ret <= 1'b1;
    @(posedge clk_in);
    ret <= 1'b0;
  endtask : back
  // Enable, wait for the core to take a request, compare its vector
  task automatic serve(input logic [15:0] exp, input bit ret_now);
    logic [7:0] n;
    n = tcnt;
    wrb(VIA_ADDR_CTRL, 8'h01);
    for (int i = 0; i < 20 && tcnt === n; i++) @(posedge clk_in);
    chk(tcnt !== n ? tvec : 16'hxxxx, exp, "vector");
    if (ret_now) back();
  endtask : serve
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rdb(VIA_ADDR_REQ0L, 8'h00);
    rdb(VIA_ADDR_MASK0L, 8'hff);
    rdb(VIA_ADDR_MASK1L, 8'hff);
    rdb(VIA_ADDR_MASK1H, 8'hff);
    rdb(8'h00, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_table();
    for (int a = 0; a < 4; a++) wrb(VIA_ADDR_MASK0L + 8'(a), 8'h00);
    for (int i = 0; i < 11; i++) begin
      pulse(19'h1 << evb[i]);
      serve(evv[i], 1);
    end
    @(posedge clk_in);
    cap0 <= 1'b1;
    cap1 <= 1'b1;
    carm <= 1'b1;
    // Matches must be ignored while capture or carrier mode is selected
    pulse((19'h1 << 9) | (19'h1 << 11) | (19'h1 << 16));
    rdb(VIA_ADDR_REQ0H, 8'h00);
    rdb(VIA_ADDR_REQ1L, 8'h00);
    pulse(19'h1 << 10);
    serve(16'h0020, 1);
    pulse(19'h1 << 12);
    serve(16'h0022, 1);
    pulse(19'h1 << 17);
    serve(16'h002a, 1);
    $display("test table done");
  endtask : t_table
  task automatic t_shared();
    logic [7:0] n;
    n = tcnt;
    wrb(VIA_ADDR_MASK0H, 8'h04);
    pulse(19'h1 << 4);
    wrb(VIA_ADDR_CTRL, 8'h01);
    repeat (6) @(posedge clk_in);
    chk({8'h00, tcnt}, {8'h00, n}, "masked taken");
    rdb(VIA_ADDR_REQ0H, 8'h04);
    wrb(VIA_ADDR_REQ0H, 8'h00);
    pulse(19'h1 << 5);
    rdb(VIA_ADDR_REQ0H, 8'h04);
    wrb(VIA_ADDR_REQ0H, 8'h00);
    wrb(VIA_ADDR_MASK0H, 8'h00);
    $display("test shared done");
  endtask : t_shared
  task automatic t_order();
    slow <= 1'b1;
    pulse((19'h1 << 8) | (19'h1 << 13));
    serve(16'h001e, 1);
    serve(16'h0024, 1);
    slow <= 1'b0;
    $display("test order done");
  endtask : t_order
  task automatic t_nest();
    wrb(VIA_ADDR_PRIO0H, 8'hfb);
    pulse(19'h1 << 8);
    serve(16'h001e, 0);
    pulse(19'h1 << 5);
    wrb(VIA_ADDR_CTRL, 8'h01);
    @(posedge clk_in);
    #1 chk({15'h0, high}, 16'h0001, "high group flag");
    serve(16'h0018, 0);
    rdb(VIA_ADDR_STATUS, 8'h18);
    back();
    back();
    wrb(VIA_ADDR_PRIO0H, 8'hff);
    $display("test nest done");
  endtask : t_nest
  task automatic t_lowvolt();
    wrb(VIA_ADDR_LOWVOLT, 8'h02);
    pulse(19'h1);
    #1 chk({15'h0, lvr}, 16'h0001, "low voltage reset");
    rdb(VIA_ADDR_REQ0L, 8'h00);
    wrb(VIA_ADDR_LOWVOLT, 8'h00);
    $display("test lowvolt done");
  endtask : t_lowvolt
  task automatic t_pins();
    wrb(VIA_ADDR_RISE_EN, 8'h01);
    wrb(VIA_ADDR_FALL_EN, 8'h02);
    pins <= 6'h01;
    serve(16'h0006, 1);
    serve(16'h0008, 1);
    $display("test pins done");
  endtask : t_pins
  // ==========================================================
  // Verdict, main sequence and watchdog
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  initial begin
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_table();
    t_shared();
    t_order();
    t_nest();
    t_lowvolt();
    t_pins();
    close_out();
  end
  initial begin
    #(25 * 8000);
    errors++;
    close_out();
  end
endmodule : via_arbiter_test
